// File: src/dpio_pkg.sv
// Purpose: Shared constants and types for the dual parallel handshake port
// Assumes: Host bus and port lines are synchronous to ref_clk
// Notes:   Control words other than a pending direction or mask word are told apart by their low nibble
package dpio_pkg;
  typedef enum logic [1:0] {MODE_OUT, MODE_IN, MODE_BIDIR, MODE_BIT} dpio_mode_e;

  localparam int         DATA_W        = 8;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         PORT_A        = 0;
  localparam int         PORT_B        = 1;

  // Control word layout
  localparam int         VEC_FLAG_BIT  = 0;
  localparam int         MODE_MSB      = 7;
  localparam int         MODE_LSB      = 6;
  localparam int         IE_BIT        = 7;
  localparam int         AND_BIT       = 6;
  localparam int         LEVEL_BIT     = 5;
  localparam int         MASKF_BIT     = 4;
  localparam logic [3:0] CW_MODE       = 4'hf;
  localparam logic [3:0] CW_INTCTL     = 4'h7;
  localparam logic [3:0] CW_INTDIS     = 4'h3;

  // Two-byte opcode that ends a service routine
  localparam logic [7:0] RET_OP_FIRST  = 8'hed;
  localparam logic [7:0] RET_OP_SECOND = 8'h4d;

  // Reset values and the byte returned on a control read
  localparam dpio_mode_e RST_MODE      = MODE_IN;
  localparam logic [7:0] RST_DIR       = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'hff;
  localparam logic [7:0] RST_VEC       = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] CTRL_RD_DATA  = 8'h00;
endpackage : dpio_pkg

// File: src/dpio_fifo.sv
// Purpose: Small synchronous FIFO for outgoing port bytes
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Flip-flop storage, combinational read port
`timescale 1ns/1ps
module dpio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : dpio_fifo

// File: src/dpio_port.sv
// Purpose: Dual 8-bit parallel port with handshake and daisy-chain interrupts
// Assumes: All inputs synchronous to ref_clk; port lines resynchronised
// Notes:   Port A output bytes queue in an 8-word FIFO in output and bidirectional modes
`timescale 1ns/1ps
module dpio_port
  import dpio_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] cpu_data_in,
  output logic      [7:0] cpu_data_out,
  output logic            cpu_data_oe_n,
  input  wire logic       chip_enable_n,
  input  wire logic       read_n,
  input  wire logic       io_request_n,
  input  wire logic       opcode_fetch_n,
  input  wire logic       port_select,
  input  wire logic       ctrl_select,
  output logic            int_req_out,
  output logic            int_req_oe_n,
  input  wire logic       chain_enable_in,
  output logic            chain_enable_out,
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe_n,
  input  wire logic       port_a_strobe_n,
  output logic            port_a_ready,
  input  wire logic [7:0] port_b_in,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe_n,
  input  wire logic       port_b_strobe_n,
  output logic            port_b_ready,
  output logic            tx_fifo_full
);
  logic [7:0] pin_in       [2];
  logic [7:0] line_s1_reg  [2];
  logic [7:0] line_s2_reg  [2];
  logic [1:0] stb_s1_reg;
  logic [1:0] stb_s2_reg;
  logic [1:0] stb_s3_reg;
  dpio_mode_e mode_reg     [2];
  logic [7:0] dir_reg      [2];
  logic [7:0] mask_reg     [2];
  logic [7:0] vec_reg      [2];
  logic [7:0] out_reg      [2];
  logic [7:0] in_reg       [2];
  logic [7:0] pin_out_reg  [2];
  logic [7:0] pin_oe_n_reg [2];
  logic [7:0] load_data    [2];
  logic [1:0] ie_reg;
  logic [1:0] and_reg;
  logic [1:0] act_hi_reg;
  logic [1:0] want_dir_reg;
  logic [1:0] want_mask_reg;
  logic [1:0] out_full_reg;
  logic [1:0] in_empty_reg;
  logic [1:0] ip_reg;
  logic [1:0] ius_reg;
  logic [1:0] hit_prev_reg;
  logic [1:0] ready_reg;
  logic [1:0] ready_next;
  logic [1:0] stb_rise;
  logic [1:0] stb_fall;
  logic [1:0] out_ack;
  logic [1:0] in_latch;
  logic [1:0] load_evt;
  logic [1:0] bit_evt;
  logic [1:0] irq_evt;
  logic [1:0] req;
  logic [1:0] ret_clr;
  logic [7:0] rd_data;
  logic [7:0] cpu_data_out_reg;
  logic [7:0] fetch_byte_reg;
  logic [7:0] fifo_out_data;
  logic       cpu_data_oe_n_reg;
  logic       int_oe_n_reg;
  logic       chain_out_reg;
  logic       tx_full_reg;
  logic       rd_prev_reg;
  logic       wr_prev_reg;
  logic       ack_prev_reg;
  logic       ack_drive_reg;
  logic       armed_reg;
  logic       fetch_seen_reg;
  logic       after_first_reg;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;

  assign pin_in[PORT_A] = port_a_in;
  assign pin_in[PORT_B] = port_b_in;

  wire bus_io   = !chip_enable_n && !io_request_n && opcode_fetch_n;
  wire rd_now   = bus_io && !read_n;
  wire wr_now   = bus_io && read_n;
  wire rd_go    = rd_now && !rd_prev_reg;
  wire wr_go    = wr_now && !wr_prev_reg;
  wire wr_ctrl  = wr_go && ctrl_select;
  wire wr_data  = wr_go && !ctrl_select;
  wire ack_now  = !io_request_n && !opcode_fetch_n;
  wire ack_go   = ack_now && !ack_prev_reg;
  wire bidir    = mode_reg[PORT_A] == MODE_BIDIR;
  wire a_stream = mode_reg[PORT_A] == MODE_OUT || bidir;
  wire ack_port = !req[PORT_A];
  wire ack_sel  = ack_go && (req != 2'b00);
  wire fetch_rd = !opcode_fetch_n && io_request_n && !read_n;
  wire fetch_end = opcode_fetch_n && fetch_seen_reg;
  wire ret_go   = fetch_end && after_first_reg && fetch_byte_reg == RET_OP_SECOND;

  assign stb_rise = stb_s2_reg & ~stb_s3_reg;
  assign stb_fall = ~stb_s2_reg & stb_s3_reg;

  assign out_ack[PORT_A]  = stb_rise[PORT_A] && a_stream;
  assign out_ack[PORT_B]  = stb_rise[PORT_B] && mode_reg[PORT_B] == MODE_OUT;
  // port B strobe fills port A
  assign in_latch[PORT_A] = (stb_fall[PORT_A] && mode_reg[PORT_A] == MODE_IN) || (stb_fall[PORT_B] && bidir);
  assign in_latch[PORT_B] = stb_fall[PORT_B] && mode_reg[PORT_B] == MODE_IN;
  assign irq_evt[PORT_A]  = out_ack[PORT_A] || (stb_fall[PORT_A] && mode_reg[PORT_A] == MODE_IN) || bit_evt[PORT_A];
  assign irq_evt[PORT_B]  = out_ack[PORT_B] || (stb_fall[PORT_B] && (mode_reg[PORT_B] == MODE_IN || bidir))
                            || bit_evt[PORT_B];

  assign fifo_out_ready    = !out_full_reg[PORT_A] && a_stream;
  assign load_evt[PORT_A]  = fifo_out_valid && fifo_out_ready;
  assign load_data[PORT_A] = fifo_out_data;
  assign load_evt[PORT_B]  = wr_data && port_select && mode_reg[PORT_B] == MODE_OUT;
  assign load_data[PORT_B] = cpu_data_in;

  // blocked while this or higher in service
  assign req[PORT_A] = ip_reg[PORT_A] && armed_reg && chain_enable_in && !ius_reg[PORT_A];
  assign req[PORT_B] = ip_reg[PORT_B] && armed_reg && chain_enable_in && ius_reg == 2'b00;
  assign ret_clr[PORT_A] = ret_go && chain_enable_in && ius_reg[PORT_A];
  assign ret_clr[PORT_B] = ret_go && chain_enable_in && !ius_reg[PORT_A] && ius_reg[PORT_B];

  dpio_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (wr_data && !port_select && a_stream),
    .in_ready  (fifo_in_ready),
    .in_data   (cpu_data_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb
  begin
    ready_next = 2'b00;
    for (int q = 0; q < 2; q++)
    begin
      case (mode_reg[q])
        MODE_OUT, MODE_BIDIR: ready_next[q] = out_full_reg[q];
        MODE_IN:              ready_next[q] = in_empty_reg[q];
        default:              ready_next[q] = 1'b0;
      endcase
    end
    if (bidir)
      ready_next[PORT_B] = in_empty_reg[PORT_A];
  end

  always_comb
  begin
    rd_data = CTRL_RD_DATA;
    if (!ctrl_select)
    begin
      case (mode_reg[port_select])
        MODE_OUT: rd_data = out_reg[port_select];
        MODE_BIT: rd_data = (out_reg[port_select] & dir_reg[port_select])
                            | (line_s2_reg[port_select] & ~dir_reg[port_select]);
        default:  rd_data = in_reg[port_select];
      endcase
    end
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam logic PSEL = 1'(p);
    wire       sel_ctrl = wr_ctrl && port_select == PSEL;
    wire       sel_data = wr_data && port_select == PSEL;
    wire       rd_evt   = rd_go && !ctrl_select && port_select == PSEL;
    wire [7:0] act      = ~(line_s2_reg[p] ^ {8{act_hi_reg[p]}});
    wire [7:0] cand     = ~mask_reg[p] & ~dir_reg[p];
    // AND or OR of active bits
    wire       hit      = and_reg[p] ? (cand != 8'h00 && (act & cand) == cand) : (act & cand) != 8'h00;
    assign bit_evt[p] = mode_reg[p] == MODE_BIT && hit && !hit_prev_reg[p];

    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        line_s1_reg[p]  <= RST_DATA;
        line_s2_reg[p]  <= RST_DATA;
        stb_s1_reg[p]   <= 1'b1;
        stb_s2_reg[p]   <= 1'b1;
        stb_s3_reg[p]   <= 1'b1;
        hit_prev_reg[p] <= 1'b0;
      end
      else
      begin
        line_s1_reg[p]  <= pin_in[p];
        line_s2_reg[p]  <= line_s1_reg[p];
        stb_s1_reg[p]   <= p == PORT_A ? port_a_strobe_n : port_b_strobe_n;
        stb_s2_reg[p]   <= stb_s1_reg[p];
        stb_s3_reg[p]   <= stb_s2_reg[p];
        hit_prev_reg[p] <= hit;
      end
    end

    // Control words; a pending direction or mask word takes priority
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        mode_reg[p]      <= RST_MODE;
        dir_reg[p]       <= RST_DIR;
        mask_reg[p]      <= RST_MASK;
        vec_reg[p]       <= RST_VEC;
        ie_reg[p]        <= 1'b0;
        and_reg[p]       <= 1'b0;
        act_hi_reg[p]    <= 1'b0;
        want_dir_reg[p]  <= 1'b0;
        want_mask_reg[p] <= 1'b0;
      end
      else if (sel_ctrl)
      begin
        if (want_dir_reg[p])
        begin
          dir_reg[p]      <= cpu_data_in;
          want_dir_reg[p] <= 1'b0;
        end
        else if (want_mask_reg[p])
        begin
          mask_reg[p]      <= cpu_data_in;
          want_mask_reg[p] <= 1'b0;
        end
        else if (!cpu_data_in[VEC_FLAG_BIT])
          vec_reg[p] <= cpu_data_in;
        else if (cpu_data_in[3:0] == CW_MODE)
        begin
          mode_reg[p] <= (p == PORT_B && cpu_data_in[MODE_MSB:MODE_LSB] == 2'(MODE_BIDIR))
                         ? MODE_IN : dpio_mode_e'(cpu_data_in[MODE_MSB:MODE_LSB]);
          want_dir_reg[p] <= cpu_data_in[MODE_MSB:MODE_LSB] == 2'(MODE_BIT);
        end
        else if (cpu_data_in[3:0] == CW_INTCTL)
        begin
          ie_reg[p]        <= cpu_data_in[IE_BIT];
          and_reg[p]       <= cpu_data_in[AND_BIT];
          act_hi_reg[p]    <= cpu_data_in[LEVEL_BIT];
          want_mask_reg[p] <= cpu_data_in[MASKF_BIT];
        end
        else if (cpu_data_in[3:0] == CW_INTDIS)
          ie_reg[p] <= cpu_data_in[IE_BIT];
      end
    end

    // Data registers and handshake flags
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        out_reg[p]      <= RST_DATA;
        in_reg[p]       <= RST_DATA;
        out_full_reg[p] <= 1'b0;
        in_empty_reg[p] <= 1'b0;
      end
      else
      begin
        if (load_evt[p])
          out_reg[p] <= load_data[p];
        else if (sel_data && mode_reg[p] != MODE_OUT && mode_reg[p] != MODE_BIDIR)
          out_reg[p] <= cpu_data_in;
        if (load_evt[p])
          out_full_reg[p] <= 1'b1;
        else if (out_ack[p])
          out_full_reg[p] <= 1'b0;
        if (in_latch[p])
          in_reg[p] <= line_s2_reg[p];
        if (in_latch[p])
          in_empty_reg[p] <= 1'b0;
        else if (rd_evt && (mode_reg[p] == MODE_IN || mode_reg[p] == MODE_BIDIR))
          in_empty_reg[p] <= 1'b1;
      end
    end

    // Pending and in-service; a new event wins over the acknowledge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        ip_reg[p]  <= 1'b0;
        ius_reg[p] <= 1'b0;
      end
      else
      begin
        if (irq_evt[p] && ie_reg[p])
          ip_reg[p] <= 1'b1;
        else if (ack_sel && ack_port == PSEL)
          ip_reg[p] <= 1'b0;
        if (ack_sel && ack_port == PSEL)
          ius_reg[p] <= 1'b1;
        else if (ret_clr[p])
          ius_reg[p] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        pin_out_reg[p]  <= RST_DATA;
        pin_oe_n_reg[p] <= 8'hff;
        ready_reg[p]    <= 1'b0;
      end
      else
      begin
        pin_out_reg[p] <= out_reg[p];
        ready_reg[p]   <= ready_next[p];
        case (mode_reg[p])
          MODE_OUT:   pin_oe_n_reg[p] <= 8'h00;
          MODE_BIDIR: pin_oe_n_reg[p] <= stb_s2_reg[p] ? 8'hff : 8'h00;
          MODE_BIT:   pin_oe_n_reg[p] <= ~dir_reg[p];
          default:    pin_oe_n_reg[p] <= 8'hff;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_prev_reg     <= 1'b0;
      wr_prev_reg     <= 1'b0;
      ack_prev_reg    <= 1'b0;
      fetch_byte_reg  <= RST_DATA;
      fetch_seen_reg  <= 1'b0;
      after_first_reg <= 1'b0;
      armed_reg       <= 1'b0;
    end
    else
    begin
      rd_prev_reg    <= rd_now;
      wr_prev_reg    <= wr_now;
      ack_prev_reg   <= ack_now;
      fetch_seen_reg <= fetch_rd || (fetch_seen_reg && !opcode_fetch_n);
      if (fetch_rd)
        fetch_byte_reg <= cpu_data_in;
      if (fetch_end)
        after_first_reg <= fetch_byte_reg == RET_OP_FIRST;
      // arm on opcode fetch after programming
      if (wr_ctrl)
        armed_reg <= 1'b0;
      else if (!opcode_fetch_n)
        armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_data_out_reg  <= RST_DATA;
      cpu_data_oe_n_reg <= 1'b1;
      ack_drive_reg     <= 1'b0;
      int_oe_n_reg      <= 1'b1;
      chain_out_reg     <= 1'b0;
      tx_full_reg       <= 1'b0;
    end
    else
    begin
      ack_drive_reg     <= ack_now && (ack_drive_reg || ack_sel);
      cpu_data_oe_n_reg <= !(rd_now || (ack_now && (ack_drive_reg || ack_sel)));
      // vector on acknowledge, low bit cleared
      if (ack_sel)
        cpu_data_out_reg <= {vec_reg[ack_port][7:1], 1'b0};
      else if (rd_now)
        cpu_data_out_reg <= rd_data;
      int_oe_n_reg  <= req == 2'b00;
      chain_out_reg <= chain_enable_in && ius_reg == 2'b00;
      tx_full_reg   <= !fifo_in_ready;
    end
  end

  assign cpu_data_out     = cpu_data_out_reg;
  assign cpu_data_oe_n    = cpu_data_oe_n_reg;
  assign int_req_out      = 1'b0;
  assign int_req_oe_n     = int_oe_n_reg;
  assign chain_enable_out = chain_out_reg;
  assign port_a_out       = pin_out_reg[PORT_A];
  assign port_a_oe_n      = pin_oe_n_reg[PORT_A];
  assign port_a_ready     = ready_reg[PORT_A];
  assign port_b_out       = pin_out_reg[PORT_B];
  assign port_b_oe_n      = pin_oe_n_reg[PORT_B];
  assign port_b_ready     = ready_reg[PORT_B];
  assign tx_fifo_full     = tx_full_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_ack_both;
    ack_sel && req == 2'b11;
  endsequence
  sequence s_b_load;
    load_evt[PORT_B] && mode_reg[PORT_B] == MODE_OUT;
  endsequence

  vec_lsb_zero_a: assert property (ack_drive_reg && !cpu_data_oe_n |-> !cpu_data_out[0])
    else $error("vector bit zero set");
  prio_a_first_a: assert property (s_ack_both |=> ius_reg == 2'b01 && ip_reg[PORT_B])
    else $error("port B served before port A");
  b_write_ready_a: assert property (s_b_load |-> ##2 port_b_ready)
    else $error("output write did not raise ready");
  bit_ready_low_a: assert property (mode_reg[PORT_B] == MODE_BIT && $past(mode_reg[PORT_B]) == MODE_BIT
                                    && !bidir && !$past(bidir) |-> !port_b_ready)
    else $error("ready high in bit mode");
  strobe_latch_a: assert property (in_latch[PORT_B] |=> in_reg[PORT_B] == $past(line_s2_reg[PORT_B])
                                   && !in_empty_reg[PORT_B])
    else $error("strobe did not latch input");
  bidir_drive_a: assert property (bidir && $past(bidir) && port_a_oe_n != 8'hff |-> !$past(stb_s2_reg[PORT_A]))
    else $error("port A driven without strobe");
  chain_block_a: assert property (ius_reg != 2'b00 |=> !chain_enable_out)
    else $error("chain out high during service");
  arm_wait_a: assert property (armed_reg && !$past(armed_reg) |-> !$past(opcode_fetch_n))
    else $error("armed without opcode fetch");
  bit_irq_a: assert property (bit_evt[PORT_B] && ie_reg[PORT_B] |=> ip_reg[PORT_B])
    else $error("bit condition did not request");
endmodule : dpio_port

// File: testbench/dpio_periph.sv
// Purpose: Peripheral model that strobes one port
// Assumes: Go is seen at a rising edge, lines change on falling edges
// Notes:   Lines show the inverse outside a strobe, nothing pulls them
`timescale 1ns/1ps
module dpio_periph (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic [1:0] hold,
  output logic      [7:0] lines,
  output logic            strobe_n,
  output logic            busy
);
  initial
  begin
    lines    = 8'h00;
    strobe_n = 1'b1;
    busy     = 1'b0;
  end
  // Prompt or slow strobe, length set by hold
  always @(posedge ref_clk)
  begin
    if (go && !busy)
    begin
      busy = 1'b1;
      @(negedge ref_clk);
      lines = data;
      repeat (2) @(negedge ref_clk);
      strobe_n = 1'b0;
      repeat (2 + hold) @(negedge ref_clk);
      strobe_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      lines = ~data;
      @(posedge ref_clk);
      busy = 1'b0;
    end
  end
endmodule : dpio_periph

// File: testbench/tb.sv
// Purpose: Self-checking bench for the dual handshake port
// Assumes: Host cycles and strobes change on falling edges
// Notes:   Read data and vectors are checked against a queue of notes
`timescale 1ns/1ps
module tb;
  import dpio_pkg::*;
  logic ref_clk = 0, resetn = 0, chip_enable_n = 1, read_n = 1, io_request_n = 1, opcode_fetch_n = 1;
  logic port_select = 0, ctrl_select = 0, chain_enable_in = 1, a_go = 0, b_go = 0, oe_d = 1;
  logic cpu_data_oe_n, int_req_out, int_req_oe_n, chain_enable_out, port_a_ready, port_b_ready, tx_fifo_full;
  logic port_a_strobe_n, port_b_strobe_n, a_busy, b_busy;
  logic [7:0] cpu_data_in = 0, cpu_data_out, port_a_in, port_a_out, port_a_oe_n, a_lines, a_dat = 0;
  logic [7:0] port_b_in, port_b_out, port_b_oe_n, b_lines, b_dat = 0, d, vec[2], exp_q[$], sent[$];
  logic [31:0] seed = 32'hd4f2;
  int num_errors = 0, tests_run = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  // Wire level: driven bits from the port, the rest from the peripheral
  assign port_a_in = (port_a_out & ~port_a_oe_n) | (a_lines & port_a_oe_n);
  assign port_b_in = (port_b_out & ~port_b_oe_n) | (b_lines & port_b_oe_n);
  dpio_port i_dut (.ref_clk, .resetn, .cpu_data_in, .cpu_data_out, .cpu_data_oe_n, .chip_enable_n,
    .read_n, .io_request_n, .opcode_fetch_n, .port_select, .ctrl_select, .int_req_out,
    .int_req_oe_n, .chain_enable_in, .chain_enable_out, .port_a_in, .port_a_out, .port_a_oe_n,
    .port_a_strobe_n, .port_a_ready, .port_b_in, .port_b_out, .port_b_oe_n, .port_b_strobe_n,
    .port_b_ready, .tx_fifo_full);
  dpio_periph i_pa (.ref_clk, .go(a_go), .data(a_dat), .hold(seed[1:0]), .lines(a_lines),
    .strobe_n(port_a_strobe_n), .busy(a_busy));
  dpio_periph i_pb (.ref_clk, .go(b_go), .data(b_dat), .hold(seed[3:2]), .lines(b_lines),
    .strobe_n(port_b_strobe_n), .busy(b_busy));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  task automatic rnd;
    seed = lfsr_step(seed);
    d = seed[7:0];
  endtask : rnd
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic bus(input logic rd, input logic b, input logic c, input logic [7:0] v);
    {read_n, port_select, ctrl_select, cpu_data_in} = {~rd, b, c, v};
    {chip_enable_n, io_request_n} = 2'b00;
    repeat (3) @(negedge ref_clk);
    {chip_enable_n, io_request_n, read_n} = 3'b111;
    @(negedge ref_clk);
  endtask : bus
  // Opcode fetch: arms interrupts and feeds the return decoder
  task automatic fetch(input logic [7:0] op);
    {read_n, opcode_fetch_n, cpu_data_in} = {2'b00, op};
    repeat (2) @(negedge ref_clk);
    {read_n, opcode_fetch_n} = 2'b11;
    @(negedge ref_clk);
  endtask : fetch
  task automatic end_service;
    fetch(RET_OP_FIRST);
    fetch(RET_OP_SECOND);
  endtask : end_service
  task automatic ack(input int p);
    for (int i = 0; i < 40 && int_req_oe_n !== 1'b0; i++) @(negedge ref_clk);
    chk1("int_req_oe_n", 1'b0, int_req_oe_n);
    chk1("int_req_out", 1'b0, int_req_out);
    exp_q.push_back(vec[p]);
    {io_request_n, opcode_fetch_n} = 2'b00;
    repeat (3) @(negedge ref_clk);
    {io_request_n, opcode_fetch_n} = 2'b11;
    @(negedge ref_clk);
  endtask : ack
  task automatic strobe(input logic a, input logic b, input logic [7:0] v);
    {a_dat, b_dat, a_go, b_go} = {v, ~v, a, b};
    @(negedge ref_clk);
    {a_go, b_go} = 2'b00;
    while (a_busy || b_busy) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
  endtask : strobe
  task automatic wrap_up;
    if (exp_q.size() != 0)
      num_errors++;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // Each new read or vector on the bus takes the oldest note
  always @(negedge ref_clk)
  begin
    if (oe_d && cpu_data_oe_n === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 8'h00, 8'hff);
      else
        chk("cpu_data_out", exp_q.pop_front(), cpu_data_out);
    end
    oe_d = cpu_data_oe_n;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    chk("port_a_oe_n", 8'hff, port_a_oe_n);
    exp_q.push_back(RST_DATA);
    bus(1, 0, 0, 8'h00);
    chk1("port_a_ready", 1'b1, port_a_ready);
    for (int p = 0; p < 2; p++)
    begin
      rnd;
      vec[p] = {d[7:1], 1'b0};
      bus(0, p[0], 1, vec[p]);
      bus(0, p[0], 1, 8'h87);
    end
    fetch(8'h00);
    rnd;
    strobe(1, 1, d);
    chk1("port_a_ready", 1'b0, port_a_ready);
    chk1("chain_enable_out", 1'b1, chain_enable_out);
    ack(0);
    chk1("chain_enable_out", 1'b0, chain_enable_out);
    chk1("int_req_oe_n", 1'b1, int_req_oe_n);
    end_service;
    ack(1);
    end_service;
    exp_q.push_back(d);
    bus(1, 0, 0, 8'h00);
    exp_q.push_back(~d);
    bus(1, 1, 0, 8'h00);
    bus(0, 1, 1, 8'h0f);
    rnd;
    bus(0, 1, 0, d);
    repeat (4) @(negedge ref_clk);
    chk("port_b_out", d, port_b_out);
    chk1("port_b_ready", 1'b1, port_b_ready);
    fetch(8'h00);
    strobe(0, 1, 8'hfe);
    chk1("port_b_ready", 1'b0, port_b_ready);
    ack(1);
    end_service;
    rnd;
    d[0] = 1'b0;
    bus(0, 1, 1, 8'hcf);
    bus(0, 1, 1, d);
    bus(0, 1, 1, 8'hb7);
    bus(0, 1, 1, 8'hfe);
    bus(0, 1, 0, seed[15:8]);
    fetch(8'h00);
    chk("port_b_oe_n", ~d, port_b_oe_n);
    chk("port_b_out", seed[15:8] & d, port_b_out & d);
    chk1("port_b_ready", 1'b0, port_b_ready);
    strobe(0, 1, 8'hfe);
    ack(1);
    end_service;
    bus(0, 1, 1, 8'h17);
    bus(0, 1, 1, 8'hff);
    bus(0, 0, 1, 8'h8f);
    while (tx_fifo_full !== 1'b1 && sent.size() < 12)
    begin
      rnd;
      sent.push_back(d);
      bus(0, 0, 0, d);
    end
    chk1("tx_fifo_full", 1'b1, tx_fifo_full);
    chk("port_a_oe_n", 8'hff, port_a_oe_n);
    foreach (sent[i])
    begin
      for (int k = 0; k < 30 && port_a_ready !== 1'b1; k++) @(negedge ref_clk);
      chk("port_a_out", sent[i], port_a_out);
      strobe(1, 0, 8'h00);
    end
    // Port B strobe fills port A input; A lines idle at inverse of last byte
    strobe(0, 1, 8'h00);
    chk1("port_b_ready", 1'b0, port_b_ready);
    exp_q.push_back(8'hff);
    bus(1, 0, 0, 8'h00);
    chk1("port_b_ready", 1'b1, port_b_ready);
    chk1("tx_fifo_full", 1'b0, tx_fifo_full);
    wrap_up;
  end
endmodule : tb
